// File: design/lps_map.svh
// Purpose: register indices, field positions, reset values and divider counts
// Assumes: 32-bit apb, one register per aligned word, byte address is index * 4
// Notes:   definitions only
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// register indices (byte address = index * 4)
`define SYSOPT_IDX      8'h11
`define MODESTAT_IDX    8'h12

// system options fields
`define LV_FLAG_BIT     7
`define LV_INT_EN_BIT   6
`define LV_PWR_BIT      5
`define BUS_CLK_SEL_BIT 4
`define IRQ_SENSE_BIT   3
`define SYSOPT_RESET    8'h00

// mode status fields
`define STAT_MODE_LSB   0
`define STAT_IRQ_BIT    2
`define STAT_LVI_BIT    3

// divider terminal counts for the bus tick
`define DIV_FAST_LAST   2'h1
`define DIV_SLOW_LAST   2'h3

`endif

// File: design/lps_pkg.sv
// Purpose: shared types of the low power and system options block
// Assumes: nothing
// Notes:   numbers live in lps_map.svh
package lps_pkg;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_HALT
  } power_mode_t;

endpackage

// File: design/clk_div_if.sv
// Purpose: links the control block to the bus clock divider
// Assumes: single clock domain
// Notes:   ctrl drives run and slow, div returns the ticks
`timescale 1ns/100ps
interface clk_div_if;
  logic run;
  logic slow;
  logic bus_tick;
  logic tone_tick;

  modport ctrl (output run, output slow, input bus_tick, input tone_tick);
  modport div  (input run, input slow, output bus_tick, output tone_tick);
endinterface

// File: design/clock_divider.sv
// Purpose: bus tick at osc/2 or osc/4, tone tick at osc/2 while run is high
// Assumes: clock is the oscillator; run low means oscillator stopped
// Notes:   ticks are one-cycle pulses from flip-flops
`timescale 1ns/100ps
`include "lps_map.svh"
module clock_divider #(
  parameter int CNT_W = 2
) (
  input  wire logic clock,
  input  wire logic reset,
  clk_div_if.div    cd
);

  generate
    if (CNT_W != 2) begin : g_bad_width
      $error("clock_divider: CNT_W must be 2");
    end
  endgenerate

  localparam logic [CNT_W-1:0] FAST_LAST = `DIV_FAST_LAST;

  logic [CNT_W-1:0] cnt_r;
  logic             bus_tick_r;
  logic             tone_tick_r;
  logic             bus_hit;

  // terminal count depends on the slow select
  assign bus_hit = cd.slow ? (cnt_r == `DIV_SLOW_LAST) : (cnt_r[0] == FAST_LAST[0]);

  // count only while the oscillator runs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r       <= '0;
      bus_tick_r  <= 1'b0;
      tone_tick_r <= 1'b0;
    end else begin
      cnt_r       <= cd.run ? cnt_r + 2'h1 : cnt_r;
      bus_tick_r  <= cd.run & bus_hit;
      tone_tick_r <= cd.run & cnt_r[0];
    end
  end

  assign cd.bus_tick  = bus_tick_r;
  assign cd.tone_tick = tone_tick_r;

  property p_slow_gap;
    @(posedge clock) disable iff (reset)
    (bus_tick_r && cd.slow && cd.run) |=> !bus_tick_r;
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("bus tick too fast in slow mode");

  property p_tone_steady;
    @(posedge clock) disable iff (reset)
    (cd.run && $past(cd.run) && $past(cd.run, 2) && !$past(reset) && !$past(reset, 2))
      |-> (tone_tick_r != $past(tone_tick_r));
  endproperty
  a_tone_steady: assert property (p_tone_steady) else $error("tone tick not osc/2");

endmodule

// File: design/low_power_system_options.sv
// Purpose: halt and wait mode control, system options register, reset pin
// Assumes: clock is the oscillator; all inputs synchronous; apb slave
// Notes:   zero-wait apb, read data sampled in the setup cycle
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "lps_map.svh"

// What this block does
// - halt stops oscillator, timers and tone
// - halt entry clears timer flags and enables
// - halt entry clears cpu interrupt mask
// - only pin, keyboard, low-voltage interrupts wake halt
// - halt disabled option makes halt a no-op
// - wait stops cpu only; timers and tone keep running
// - any enabled interrupt or reset ends wait
// - wait entry clears cpu interrupt mask
// - one 8-bit options register, resets zero
// - low-voltage flag needs option, power, enable
// - clearing enable clears flag; setting rearms
// - flag with mask clear requests interrupt
// - bus clock select: osc/4 set, osc/2 clear
// - tone clock stays osc/2 except in halt
// - sensitivity bit: edge and level, else edge
// - detector usable only with reset option fitted
// - low reset pin forces known state
// - low-voltage reset drives reset pin open-drain
// - port lines are inputs during reset
module low_power_system_options
  import lps_pkg::*;
#(
  parameter int HALT_ENABLE = 1,
  parameter int LVR_FITTED  = 1
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_req,
  input  wire logic        wait_req,
  input  wire logic        int_mask,
  input  wire logic        irq_pin,
  input  wire logic        irq_ack,
  input  wire logic        kbd_int_req,
  input  wire logic        core_timer_int_req,
  input  wire logic        timer16_int_req,
  input  wire logic        low_voltage_detect,
  input  wire logic        lvr_detect,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             system_reset,
  output logic             ports_as_inputs,
  output logic             osc_enable,
  output logic             cpu_run,
  output logic             timers_run,
  output logic             tone_run,
  output logic             timer_irq_clear,
  output logic             int_mask_clear,
  output logic             irq_int_req,
  output logic             low_voltage_interrupt,
  output logic             bus_tick,
  output logic             tone_tick
);

  generate
    if ((HALT_ENABLE != 0 && HALT_ENABLE != 1) || (LVR_FITTED != 0 && LVR_FITTED != 1))
    begin : g_bad_option
      $error("low_power_system_options: options must be 0 or 1");
    end
  endgenerate

  power_mode_t mode_r;
  power_mode_t mode_nxt;
  logic        lv_flag_r;
  logic        lv_int_en_r;
  logic        lv_pwr_r;
  logic        bus_clk_sel_r;
  logic        irq_sense_r;
  logic        irq_prev_r;
  logic        irq_latch_r;
  logic        irq_int_req_r;
  logic        lvi_req_r;
  logic        osc_enable_r;
  logic        cpu_run_r;
  logic        timers_run_r;
  logic        tone_run_r;
  logic        timer_irq_clear_r;
  logic        int_mask_clear_r;
  logic        system_reset_r;
  logic        ports_in_r;
  logic        reset_pin_oe_r;
  logic        reset_pin_out_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  clk_div_if cd ();

  // bus decode
  logic        setup_cyc;
  logic        access_cyc;
  logic        word_ok;
  logic        hit_sysopt;
  logic        hit_stat;
  logic        wr_sysopt;
  logic [7:0]  sysopt_rd;
  logic [7:0]  stat_rd;
  logic [31:0] rd_data;

  assign setup_cyc  = psel & ~penable;
  assign access_cyc = psel & penable & pready_r;
  assign word_ok    = (paddr[1:0] == 2'h0);
  assign hit_sysopt = word_ok & (paddr[7:2] == 6'(`SYSOPT_IDX));
  assign hit_stat   = word_ok & (paddr[7:2] == 6'(`MODESTAT_IDX));
  assign wr_sysopt  = access_cyc & pwrite & hit_sysopt & ~pslverr_r;

  // read images; low option bits are constant zero
  assign sysopt_rd = {lv_flag_r, lv_int_en_r, lv_pwr_r, bus_clk_sel_r, irq_sense_r, 3'h0};
  assign stat_rd   = {4'h0, lvi_req_r, irq_int_req_r, mode_r};
  assign rd_data   = hit_sysopt ? {24'h0, sysopt_rd} : (hit_stat ? {24'h0, stat_rd} : 32'h0);

  // internal reset sources: pin low or low-voltage reset
  logic soft_reset;
  assign soft_reset = ~reset_pin_in | lvr_detect;

  // options register next values; flag only bit is not writable
  logic lv_int_en_nxt;
  logic lv_pwr_nxt;
  logic bus_clk_sel_nxt;
  logic irq_sense_nxt;
  logic lv_set;
  logic lv_flag_nxt;

  assign lv_int_en_nxt   = soft_reset ? 1'b0 : (wr_sysopt ? pwdata[`LV_INT_EN_BIT] : lv_int_en_r);
  assign lv_pwr_nxt      = soft_reset ? 1'b0 : (wr_sysopt ? pwdata[`LV_PWR_BIT] : lv_pwr_r);
  assign bus_clk_sel_nxt = soft_reset ? 1'b0 :
                           (wr_sysopt ? pwdata[`BUS_CLK_SEL_BIT] : bus_clk_sel_r);
  assign irq_sense_nxt   = soft_reset ? 1'b0 :
                           (wr_sysopt ? pwdata[`IRQ_SENSE_BIT] : irq_sense_r);
  // detector shares the reset reference, so it only works with that option
  assign lv_set      = (LVR_FITTED != 0) & lv_pwr_r & lv_int_en_r & low_voltage_detect;
  assign lv_flag_nxt = lv_int_en_nxt & (lv_flag_r | lv_set);

  // options register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lv_flag_r     <= 1'(`SYSOPT_RESET >> `LV_FLAG_BIT);
      lv_int_en_r   <= 1'b0;
      lv_pwr_r      <= 1'b0;
      bus_clk_sel_r <= 1'b0;
      irq_sense_r   <= 1'b0;
    end else begin
      lv_flag_r     <= lv_flag_nxt;
      lv_int_en_r   <= lv_int_en_nxt;
      lv_pwr_r      <= lv_pwr_nxt;
      bus_clk_sel_r <= bus_clk_sel_nxt;
      irq_sense_r   <= irq_sense_nxt;
    end
  end

  // external pin: falling edge latched, low level added when selected
  logic irq_edge;
  logic irq_latch_nxt;
  logic irq_req_nxt;
  assign irq_edge      = irq_prev_r & ~irq_pin;
  assign irq_latch_nxt = ~soft_reset & (irq_edge | (irq_latch_r & ~irq_ack)); // set wins
  assign irq_req_nxt   = irq_latch_nxt | (~soft_reset & irq_sense_r & ~irq_pin);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_prev_r    <= 1'b1;
      irq_latch_r   <= 1'b0;
      irq_int_req_r <= 1'b0;
      lvi_req_r     <= 1'b0;
    end else begin
      irq_prev_r    <= irq_pin;
      irq_latch_r   <= irq_latch_nxt;
      irq_int_req_r <= irq_req_nxt;
      lvi_req_r     <= lv_flag_nxt & ~int_mask;
    end
  end

  // wake conditions per low-power mode
  logic wake_halt;
  logic wake_wait;
  logic enter_halt;
  logic enter_wait;
  assign wake_halt  = irq_int_req_r | kbd_int_req | lvi_req_r;
  assign wake_wait  = wake_halt | core_timer_int_req | timer16_int_req;
  assign enter_halt = ~soft_reset & (mode_r == MODE_RUN) & halt_req & (HALT_ENABLE != 0);
  assign enter_wait = ~soft_reset & (mode_r == MODE_RUN) & wait_req & ~enter_halt &
                      ~(halt_req & (HALT_ENABLE != 0));

  // mode sequencing; any reset returns to run
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN: begin
        if (enter_halt) begin
          mode_nxt = MODE_HALT;
        end else if (enter_wait) begin
          mode_nxt = MODE_WAIT;
        end
      end
      MODE_HALT: begin
        if (wake_halt) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_WAIT: begin
        if (wake_wait) begin
          mode_nxt = MODE_RUN;
        end
      end
      default: mode_nxt = MODE_RUN;
    endcase
    if (soft_reset) begin
      mode_nxt = MODE_RUN;
    end
  end

  // mode register and the run enables it steers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_r            <= MODE_RUN;
      osc_enable_r      <= 1'b1;
      cpu_run_r         <= 1'b1;
      timers_run_r      <= 1'b1;
      tone_run_r        <= 1'b1;
      timer_irq_clear_r <= 1'b0;
      int_mask_clear_r  <= 1'b0;
    end else begin
      mode_r            <= mode_nxt;
      osc_enable_r      <= (mode_nxt != MODE_HALT);
      cpu_run_r         <= (mode_nxt == MODE_RUN);
      timers_run_r      <= (mode_nxt != MODE_HALT);
      tone_run_r        <= (mode_nxt != MODE_HALT);
      timer_irq_clear_r <= enter_halt;
      int_mask_clear_r  <= enter_halt | enter_wait;
    end
  end

  // reset pin and port direction control
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      system_reset_r  <= 1'b1;
      ports_in_r      <= 1'b1;
      reset_pin_oe_r  <= 1'b0;
      reset_pin_out_r <= 1'b0;
    end else begin
      system_reset_r  <= soft_reset;
      ports_in_r      <= soft_reset;
      reset_pin_oe_r  <= lvr_detect;
      reset_pin_out_r <= 1'b0;
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup_cyc;
      pslverr_r <= setup_cyc & ~(hit_sysopt | hit_stat);
      prdata_r  <= (setup_cyc & ~pwrite) ? rd_data : 32'h0;
    end
  end

  assign cd.run  = osc_enable_r;
  assign cd.slow = bus_clk_sel_r;

  clock_divider #(
    .CNT_W (2)
  ) u_div (
    .clock (clock),
    .reset (reset),
    .cd    (cd)
  );

  assign prdata                = prdata_r;
  assign pready                = pready_r;
  assign pslverr               = pslverr_r;
  assign reset_pin_out         = reset_pin_out_r;
  assign reset_pin_oe          = reset_pin_oe_r;
  assign system_reset          = system_reset_r;
  assign ports_as_inputs       = ports_in_r;
  assign osc_enable            = osc_enable_r;
  assign cpu_run               = cpu_run_r;
  assign timers_run            = timers_run_r;
  assign tone_run              = tone_run_r;
  assign timer_irq_clear       = timer_irq_clear_r;
  assign int_mask_clear        = int_mask_clear_r;
  assign irq_int_req           = irq_int_req_r;
  assign low_voltage_interrupt = lvi_req_r;
  assign bus_tick              = cd.bus_tick;
  assign tone_tick             = cd.tone_tick;

  // checks on mode control
  property p_halt_stop;
    @(posedge clock) disable iff (reset)
    enter_halt |=> !osc_enable_r && !timers_run_r && !cpu_run_r;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt left clocks running");

  property p_halt_clear;
    @(posedge clock) disable iff (reset)
    enter_halt |=> timer_irq_clear_r ##1 !timer_irq_clear_r;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("timer clear pulse wrong");

  property p_halt_mask;
    @(posedge clock) disable iff (reset)
    enter_halt |=> int_mask_clear_r && mode_r == MODE_HALT;
  endproperty
  a_halt_mask: assert property (p_halt_mask) else $error("mask not cleared on halt");

  property p_halt_hold;
    @(posedge clock) disable iff (reset)
    (mode_r == MODE_HALT && !wake_halt && !soft_reset) |=> mode_r == MODE_HALT;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without wake");

  property p_halt_nop;
    @(posedge clock) disable iff (reset)
    (HALT_ENABLE == 0 && mode_r == MODE_RUN && halt_req && !wait_req) |=> mode_r == MODE_RUN;
  endproperty
  a_halt_nop: assert property (p_halt_nop) else $error("disabled halt not a no-op");

  property p_wait_run;
    @(posedge clock) disable iff (reset)
    mode_r == MODE_WAIT |-> timers_run_r && tone_run_r && osc_enable_r && !cpu_run_r;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("wait run enables wrong");

  property p_wait_exit;
    @(posedge clock) disable iff (reset)
    (mode_r == MODE_WAIT && (core_timer_int_req || timer16_int_req)) |=> mode_r == MODE_RUN;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("wait not left on timer");

  property p_wait_mask;
    @(posedge clock) disable iff (reset)
    enter_wait |=> int_mask_clear_r && mode_r == MODE_WAIT;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("mask not cleared on wait");

  // checks on options register and pins
  property p_lv_cause;
    @(posedge clock) disable iff (reset)
    $rose(lv_flag_r) |-> $past(LVR_FITTED != 0 && low_voltage_detect && lv_pwr_r && lv_int_en_r);
  endproperty
  a_lv_cause: assert property (p_lv_cause) else $error("flag set without cause");

  property p_lv_clear;
    @(posedge clock) disable iff (reset)
    !lv_int_en_r |-> !lv_flag_r;
  endproperty
  a_lv_clear: assert property (p_lv_clear) else $error("flag set while disabled");

  property p_lv_req;
    @(posedge clock) disable iff (reset)
    ##1 (lvi_req_r == (lv_flag_r && !$past(int_mask)));
  endproperty
  a_lv_req: assert property (p_lv_req) else $error("low-voltage request wrong");

  property p_irq_level;
    @(posedge clock) disable iff (reset)
    (irq_sense_r && !irq_pin && !soft_reset) |=> irq_int_req_r;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("level request missed");

  property p_pin_reset;
    @(posedge clock) disable iff (reset)
    !reset_pin_in |=> system_reset_r && ports_in_r && mode_r == MODE_RUN && !lv_int_en_r;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");

  property p_pin_drive;
    @(posedge clock) disable iff (reset)
    ##1 (reset_pin_oe_r == $past(lvr_detect)) && !reset_pin_out_r;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("reset pin drive wrong");

  property p_low_zero;
    @(posedge clock) disable iff (reset)
    (pready_r && hit_sysopt) |-> prdata_r[2:0] == 3'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low option bits not zero");

  c_halt_wake: cover property (@(posedge clock) disable iff (reset)
    mode_r == MODE_HALT ##1 mode_r == MODE_RUN);
  c_wait_wake: cover property (@(posedge clock) disable iff (reset)
    mode_r == MODE_WAIT ##1 mode_r == MODE_RUN);
  c_lv_flag: cover property (@(posedge clock) disable iff (reset) $rose(lv_flag_r));

endmodule

// File: verif/cpu_partner.sv
// Purpose: cpu core, timer and interrupt source model facing the low power block
// Assumes: bench commands arrive at rising edges as one-cycle pulses
// Notes:   mask is set by reset; unmasked pin requests are acknowledged
`timescale 1ns/100ps
module cpu_partner (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic cpu_run,
  input  wire logic int_mask_clear,
  input  wire logic timer_irq_clear,
  input  wire logic irq_int_req,
  input  wire logic set_mask,
  input  wire logic arm_timers,
  input  wire logic halt_cmd,
  input  wire logic wait_cmd,
  output logic      halt_req,
  output logic      wait_req,
  output logic      int_mask,
  output logic      timer_int,
  output logic      irq_ack
);
  logic armed_r;

  // the core only executes halt or wait while it runs
  assign halt_req  = halt_cmd & cpu_run;
  assign wait_req  = wait_cmd & cpu_run;
  assign timer_int = armed_r;

  // mask bit, timer enables and pin acknowledge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      int_mask <= 1'b1;
      armed_r  <= 1'b0;
      irq_ack  <= 1'b0;
    end else begin
      if (int_mask_clear) int_mask <= 1'b0;
      else if (set_mask) int_mask <= 1'b1;
      if (timer_irq_clear) armed_r <= 1'b0;
      else if (arm_timers) armed_r <= 1'b1;
      irq_ack <= irq_int_req & ~int_mask & cpu_run & ~irq_ack;
    end
  end
endmodule

// File: verif/low_power_system_options_bench.sv
// Purpose: self-checking bench of the low power and system options block
// Assumes: zero-wait apb slave, options at 0x44, status at 0x48
// Notes:   register rows in a table, modes and pins tested by hand
`timescale 1ns/100ps
module low_power_system_options_bench;
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic        err;
  } row_t;

  logic        clock, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        halt_req, wait_req, int_mask, irq_pin, irq_ack, kbd_int_req;
  logic        timer_int, low_voltage_detect, lvr_detect, ext_reset_n;
  logic        reset_pin_out, reset_pin_oe, system_reset, ports_as_inputs;
  logic        osc_enable, cpu_run, timers_run, tone_run, timer_irq_clear;
  logic        int_mask_clear, irq_int_req, low_voltage_interrupt, bus_tick;
  logic        tone_tick, set_mask, arm_timers, halt_cmd, wait_cmd;
  wire         reset_pin = reset_pin_oe ? 1'b0 : ext_reset_n;  // pulled up
  logic        osc_b, lvi_b;
  int          miscompares, total_checks, cycles, n_bus, n_tone;
  row_t        rows [5] = '{
    '{8'h44, 32'hffff_ffff, 32'h0000_0078, 1'b0},
    '{8'h44, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{8'h48, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{8'h40, 32'h0000_0018, 32'h0000_0000, 1'b1},
    '{8'h45, 32'h0000_0018, 32'h0000_0000, 1'b1}};

  low_power_system_options DUT (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_req(halt_req), .wait_req(wait_req), .int_mask(int_mask),
    .irq_pin(irq_pin), .irq_ack(irq_ack), .kbd_int_req(kbd_int_req),
    .core_timer_int_req(timer_int), .timer16_int_req(timer_int),
    .low_voltage_detect(low_voltage_detect), .lvr_detect(lvr_detect),
    .reset_pin_in(reset_pin), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .system_reset(system_reset),
    .ports_as_inputs(ports_as_inputs), .osc_enable(osc_enable), .cpu_run(cpu_run),
    .timers_run(timers_run), .tone_run(tone_run), .timer_irq_clear(timer_irq_clear),
    .int_mask_clear(int_mask_clear), .irq_int_req(irq_int_req),
    .low_voltage_interrupt(low_voltage_interrupt), .bus_tick(bus_tick),
    .tone_tick(tone_tick));

  // second build: halt option off, no low-voltage reset option
  low_power_system_options #(
    .HALT_ENABLE(0), .LVR_FITTED(0)
  ) DUT_B (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .halt_req(halt_req), .wait_req(wait_req), .int_mask(int_mask), .irq_pin(irq_pin),
    .irq_ack(irq_ack), .kbd_int_req(kbd_int_req), .core_timer_int_req(timer_int),
    .timer16_int_req(timer_int), .low_voltage_detect(low_voltage_detect),
    .lvr_detect(lvr_detect), .reset_pin_in(reset_pin), .reset_pin_out(),
    .reset_pin_oe(), .system_reset(), .ports_as_inputs(), .osc_enable(osc_b),
    .cpu_run(), .timers_run(), .tone_run(), .timer_irq_clear(), .int_mask_clear(),
    .irq_int_req(), .low_voltage_interrupt(lvi_b), .bus_tick(), .tone_tick());

  cpu_partner PARTNER (
    .clock(clock), .reset(reset), .cpu_run(cpu_run), .int_mask_clear(int_mask_clear),
    .timer_irq_clear(timer_irq_clear), .irq_int_req(irq_int_req), .set_mask(set_mask),
    .arm_timers(arm_timers), .halt_cmd(halt_cmd), .wait_cmd(wait_cmd),
    .halt_req(halt_req), .wait_req(wait_req), .int_mask(int_mask),
    .timer_int(timer_int), .irq_ack(irq_ack));

  // 10 MHz oscillator clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for a level
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 50) begin
      @(posedge clock);
      n++;
    end
  endtask

  // one-cycle command pulse: 8 mask, 4 arm, 2 halt, 1 wait
  task automatic pulse(input logic [3:0] sel);
    @(posedge clock);
    {set_mask, arm_timers, halt_cmd, wait_cmd} <= sel;
    @(posedge clock);
    {set_mask, arm_timers, halt_cmd, wait_cmd} <= 4'h0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, kbd_int_req, low_voltage_detect} = '0;
    {lvr_detect, set_mask, arm_timers, halt_cmd, wait_cmd} = '0;
    {irq_pin, ext_reset_n, reset} = 3'b111;
    repeat (4) @(posedge clock);
    check(system_reset, 1'b1);
    check(ports_as_inputs, 1'b1);
    reset <= 1'b0;
    apb(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      check(err, rows[i].err);
      apb(1'b0, rows[i].addr, 32'h0);
      check(rd, rows[i].rexp);
      check(err, rows[i].err);
    end
    for (int sc = 0; sc < 2; sc++) begin
      apb(1'b1, 8'h44, {27'h0, sc[0], 4'h0});
      n_bus = 0;
      n_tone = 0;
      repeat (16) begin
        @(posedge clock);
        n_bus += bus_tick;
        n_tone += tone_tick;
      end
      check(n_bus, sc ? 4 : 8);
      check(n_tone, 8);
    end
    apb(1'b1, 8'h44, 32'h0);
    // wait mode, woken by a timer request
    pulse(4'h8);
    pulse(4'h1);
    wait_lvl(cpu_run, 1'b0);
    check(cpu_run, 1'b0);
    check({timers_run, tone_run, osc_enable}, 3'b111);
    @(posedge clock);
    check(int_mask, 1'b0);
    pulse(4'h4);
    wait_lvl(cpu_run, 1'b1);
    check(cpu_run, 1'b1);
    // halt mode with timers armed
    pulse(4'h2);
    wait_lvl(osc_enable, 1'b0);
    @(posedge clock);
    check({osc_enable, timers_run, cpu_run}, 3'b000);
    check(timer_int, 1'b0);
    check(int_mask, 1'b0);
    check(osc_b, 1'b1);
    pulse(4'h8);
    pulse(4'h4);
    repeat (6) @(posedge clock);
    check(osc_enable, 1'b0);
    kbd_int_req <= 1'b1;
    wait_lvl(osc_enable, 1'b1);
    check({osc_enable, cpu_run}, 2'b11);
    kbd_int_req <= 1'b0;
    check(int_mask, 1'b1);
    // low voltage detector; enable first, then power, then both
    apb(1'b1, 8'h44, 32'h40);
    low_voltage_detect <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, 8'h44, 32'h0);
    check(rd, 32'h40);
    apb(1'b1, 8'h44, 32'h20);
    apb(1'b1, 8'h44, 32'h60);
    repeat (3) @(posedge clock);
    apb(1'b0, 8'h44, 32'h0);
    check(rd, 32'he0);
    check(low_voltage_interrupt, 1'b0);
    pulse(4'h1);
    repeat (3) @(posedge clock);
    check(low_voltage_interrupt, 1'b1);
    check(lvi_b, 1'b0);
    low_voltage_detect <= 1'b0;
    apb(1'b1, 8'h44, 32'h20);
    apb(1'b0, 8'h44, 32'h0);
    check(rd, 32'h20);
    check(low_voltage_interrupt, 1'b0);
    // pin interrupt, edge then edge and level
    apb(1'b1, 8'h44, 32'h0);
    irq_pin <= 1'b0;
    wait_lvl(irq_int_req, 1'b1);
    check(irq_int_req, 1'b1);
    repeat (4) @(posedge clock);
    check(irq_int_req, 1'b0);
    apb(1'b1, 8'h44, 32'h08);
    repeat (4) @(posedge clock);
    check(irq_int_req, 1'b1);
    irq_pin <= 1'b1;
    // internal low-voltage reset, then external pin reset
    apb(1'b1, 8'h44, 32'h10);
    lvr_detect <= 1'b1;
    repeat (3) @(posedge clock);
    check({reset_pin_oe, reset_pin_out, system_reset}, 3'b101);
    lvr_detect <= 1'b0;
    repeat (3) @(posedge clock);
    check(system_reset, 1'b0);
    apb(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0);
    ext_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    check({system_reset, ports_as_inputs}, 2'b11);
    check(reset_pin_oe, 1'b0);
    ext_reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    results();
  end
endmodule
